// *** include/ecp_host_pkg.sv ***
// Constants and types for the ECP parallel port host controller
package ecp_host_pkg;

	// ------------------------------------------------------------
	// Device register map
	// ------------------------------------------------------------
	localparam logic [15:0] PRIMARY_BASE_DEF = 16'h0378;
	localparam logic [15:0] SECONDARY_OFS    = 16'h0400;
	localparam logic [15:0] OFS_DATA         = 16'h0000;
	localparam logic [15:0] OFS_STATUS       = 16'h0001;
	localparam logic [15:0] OFS_CONTROL      = 16'h0002;

	// Field positions
	localparam int ECR_MODE_LSB  = 5;
	localparam int ECR_DMA_BIT   = 3;
	localparam int ECR_SVC_BIT   = 2;
	localparam int ECR_EMPTY_BIT = 0;
	localparam int DCR_DIR_BIT   = 5;
	localparam int DSR_NBUSY_BIT = 7;

	// Mode field codes
	localparam logic [2:0] MODE_STD    = 3'h0;
	localparam logic [2:0] MODE_BIDIR  = 3'h1;
	localparam logic [2:0] MODE_FIFO   = 3'h2;
	localparam logic [2:0] MODE_ECP    = 3'h3;
	localparam logic [2:0] MODE_TEST   = 3'h6;
	localparam logic [2:0] MODE_CONFIG = 3'h7;

	// Register values written and flag masks polled by the sequences
	localparam logic [4:0] ECR_LOW_IDLE = 5'h14;
	localparam logic [7:0] ECR_STD      = {MODE_STD, ECR_LOW_IDLE};
	localparam logic [7:0] ECR_BIDIR    = {MODE_BIDIR, ECR_LOW_IDLE};
	localparam logic [7:0] ECR_ECP      = {MODE_ECP, ECR_LOW_IDLE};
	localparam logic [7:0] ECR_ECP_DMAS = 8'h7C;
	localparam logic [7:0] ECR_ECP_DMA  = 8'h78;
	localparam logic [7:0] DCR_FWD      = 8'h04;
	localparam logic [7:0] DCR_REV      = 8'h24;
	localparam logic [7:0] ECR_FULL_MSK = 8'h02;
	localparam logic [7:0] ECR_EMPT_MSK = 8'h01;
	localparam logic [7:0] DSR_NBSY_MSK = 8'h80;
	localparam logic [7:0] VAL_ZERO     = 8'h00;

	// ------------------------------------------------------------
	// Bus timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 20;
	localparam int T_SETUP_NS     = 10;
	localparam int T_STROBE_NS    = 100;
	localparam int T_HOLD_NS      = 15;
	localparam int SYNC_STAGES    = 2;
	localparam int SETUP_CYC      = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC     = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
	                                + SYNC_STAGES;
	localparam int HOLD_CYC       = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ENTER = 4'h0, OP_WR_DATA = 4'h1, OP_WR_ADDR = 4'h2, OP_RD_DATA = 4'h3,
		OP_TO_REV = 4'h4, OP_TO_FWD = 4'h5, OP_EXIT = 4'h6, OP_DMA_START = 4'h7,
		OP_DMA_STOP = 4'h8, OP_DMA_RESUME = 4'h9
	} op_t;

	typedef enum logic [2:0] {
		K_END = 3'h0, K_WR = 3'h1, K_RD = 3'h2, K_POLL = 3'h3, K_DMA = 3'h4
	} kind_t;

	typedef enum logic [2:0] {
		R_DFIFO = 3'h0, R_AFIFO = 3'h1, R_STATUS = 3'h2, R_CONTROL = 3'h3, R_EXT = 3'h4
	} sel_t;

	typedef struct packed {
		op_t        op;
		logic [7:0] data;
	} cmd_t;

	typedef struct packed {
		kind_t      kind;
		sel_t       sel;
		logic       use_data;
		logic [7:0] val;
		logic [7:0] mask;
	} step_t;

endpackage : ecp_host_pkg

// *** verilog/ecp_rx_buffer.sv ***
// Two-entry buffer with registered outputs for bytes read from the port
`timescale 1ns/100ps
module ecp_rx_buffer
	import ecp_host_pkg::*;
#(
	parameter int WIDTH = 8
)(
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             push_valid_in,
	output logic                  push_ready_out,
	input  wire logic [WIDTH-1:0] push_data_in,
	output logic                  pop_valid_out,
	input  wire logic             pop_ready_in,
	output logic      [WIDTH-1:0] pop_data_out
);

	logic [WIDTH-1:0] head_r;
	logic [WIDTH-1:0] tail_r;
	logic             head_v_r;
	logic             tail_v_r;
	logic             push_w;
	logic             pop_w;

	// Full when the second slot holds a word
	assign push_ready_out = !tail_v_r;
	assign push_w         = push_valid_in && !tail_v_r;
	assign pop_w          = head_v_r && pop_ready_in;
	assign pop_valid_out  = head_v_r;
	assign pop_data_out   = head_r;

	// ------------------------------------------------------------
	// Slot update
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
			head_r   <= '0;
			tail_r   <= '0;
		end
		else
		begin
			if (pop_w)
			begin
				head_v_r <= tail_v_r || push_w;
				head_r   <= tail_v_r ? tail_r : push_data_in;
				tail_v_r <= tail_v_r && push_w;
				if (tail_v_r && push_w)
					tail_r <= push_data_in;
			end
			else if (push_w)
			begin
				if (!head_v_r)
				begin
					head_v_r <= 1'b1;
					head_r   <= push_data_in;
				end
				else
				begin
					tail_v_r <= 1'b1;
					tail_r   <= push_data_in;
				end
			end
		end
	end

endmodule : ecp_rx_buffer

// *** verilog/ecp_host_ctrl.sv ***
// Host-side controller driving an ECP parallel port through its ISA registers
//
// Summary of operation
// - Forward exit: FIFO empty and handshake outputs off before mode 000/001.
// - Reverse exit: FIFO drained empty before returning to mode 000/001.
// - Pass through standard mode and negotiate before any ECP operation (no negotiation is done: mode 000, DCR lines idle, then mode 011).
// - ECP entry: mode 011, direction 0, strobe and auto-feed bits cleared.
// - Direction change only via mode 001, then back to ECP mode.
// - DMA start: set mode, program controller, enable DMA, clear service, unmask.
// - DMA stop: disable controller, set service bit, clear DMA enable.
// - DMA resume: enable controller, set DMA enable, clear service bit.
// - After forward transfer wait for FIFO empty and busy low.
// - Reverse burst reads never exceed what the FIFO holds.
`timescale 1ns/100ps
module ecp_host_ctrl
	import ecp_host_pkg::*;
#(
	parameter logic [15:0] PRIMARY_BASE = PRIMARY_BASE_DEF
)(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        cmd_valid_in,
	input  wire cmd_t        cmd_in,
	output logic             cmd_ready_out,
	output logic             rx_valid_out,
	input  wire logic        rx_ready_in,
	output logic [7:0]       rx_data_out,
	output logic [7:0]       status_out,
	output logic [15:0]      io_addr_out,
	output logic             io_rd_n_out,
	output logic             io_wr_n_out,
	input  wire logic [7:0]  sd_in,
	output logic [7:0]       sd_out,
	output logic             sd_oe_out,
	output logic             dma_ctrl_en_out,
	output logic             dma_unmask_out
);

	localparam logic [15:0] ADDR_DFIFO = PRIMARY_BASE + SECONDARY_OFS + OFS_DATA;
	localparam logic [15:0] ADDR_ECR   = PRIMARY_BASE + SECONDARY_OFS + OFS_CONTROL;
	localparam logic [15:0] ADDR_DCR   = PRIMARY_BASE + OFS_CONTROL;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01, S_FETCH = 5'h02, S_SETUP = 5'h04, S_STROBE = 5'h08, S_HOLD = 5'h10
	} state_t;

	state_t      state_r;
	cmd_t        cmd_r;
	step_t       step_w;
	logic [2:0]  idx_r;
	logic [2:0]  cnt_r;
	logic [7:0]  sd_meta_r;
	logic [7:0]  sd_sync_r;
	logic [7:0]  rdata_r;
	logic        buf_ready_w;
	logic        push_w;
	logic        hold_done_w;

	// ------------------------------------------------------------
	// Sequence table: one short program per command
	// ------------------------------------------------------------
	function automatic step_t step_of(input op_t op, input logic [2:0] i);
		step_t s;
		s = '{K_END, R_EXT, 1'b0, VAL_ZERO, VAL_ZERO};
		case ({op, i})
			// Standard mode first, lines idle, then ECP forward
			{OP_ENTER, 3'h0}:      s = '{K_WR, R_EXT, 1'b0, ECR_STD, VAL_ZERO};
			{OP_ENTER, 3'h1}:      s = '{K_WR, R_CONTROL, 1'b0, DCR_FWD, VAL_ZERO};
			{OP_ENTER, 3'h2}:      s = '{K_WR, R_EXT, 1'b0, ECR_ECP, VAL_ZERO};
			// Byte writes wait for room in the device FIFO
			{OP_WR_DATA, 3'h0},
			{OP_WR_ADDR, 3'h0}:    s = '{K_POLL, R_EXT, 1'b0, VAL_ZERO, ECR_FULL_MSK};
			{OP_WR_DATA, 3'h1}:    s = '{K_WR, R_DFIFO, 1'b1, VAL_ZERO, VAL_ZERO};
			{OP_WR_ADDR, 3'h1}:    s = '{K_WR, R_AFIFO, 1'b1, VAL_ZERO, VAL_ZERO};
			// Reads only while the FIFO reports data
			{OP_RD_DATA, 3'h0}:    s = '{K_POLL, R_EXT, 1'b0, VAL_ZERO, ECR_EMPT_MSK};
			{OP_RD_DATA, 3'h1}:    s = '{K_RD, R_DFIFO, 1'b0, VAL_ZERO, VAL_ZERO};
			// Turnarounds go through mode 001 with an empty FIFO
			{OP_TO_REV, 3'h0},
			{OP_TO_FWD, 3'h0},
			{OP_EXIT, 3'h0}:       s = '{K_POLL, R_EXT, 1'b0, ECR_EMPT_MSK, ECR_EMPT_MSK};
			{OP_TO_REV, 3'h1},
			{OP_EXIT, 3'h1}:       s = '{K_POLL, R_STATUS, 1'b0, DSR_NBSY_MSK, DSR_NBSY_MSK};
			{OP_TO_REV, 3'h2},
			{OP_TO_FWD, 3'h1},
			{OP_EXIT, 3'h2}:       s = '{K_WR, R_EXT, 1'b0, ECR_BIDIR, VAL_ZERO};
			{OP_TO_REV, 3'h3}:     s = '{K_WR, R_CONTROL, 1'b0, DCR_REV, VAL_ZERO};
			{OP_TO_FWD, 3'h2},
			{OP_EXIT, 3'h3}:       s = '{K_WR, R_CONTROL, 1'b0, DCR_FWD, VAL_ZERO};
			{OP_TO_REV, 3'h4},
			{OP_TO_FWD, 3'h3}:     s = '{K_WR, R_EXT, 1'b0, ECR_ECP, VAL_ZERO};
			// DMA start: controller on, enable, clear service, unmask last
			{OP_DMA_START, 3'h0}:  s = '{K_DMA, R_EXT, 1'b0, 8'h02, VAL_ZERO};
			{OP_DMA_START, 3'h1},
			{OP_DMA_RESUME, 3'h1}: s = '{K_WR, R_EXT, 1'b0, ECR_ECP_DMAS, VAL_ZERO};
			{OP_DMA_START, 3'h2},
			{OP_DMA_RESUME, 3'h2}: s = '{K_WR, R_EXT, 1'b0, ECR_ECP_DMA, VAL_ZERO};
			{OP_DMA_START, 3'h3}:  s = '{K_DMA, R_EXT, 1'b0, 8'h03, VAL_ZERO};
			// DMA stop: controller off, service set, enable cleared
			{OP_DMA_STOP, 3'h0}:   s = '{K_DMA, R_EXT, 1'b0, 8'h01, VAL_ZERO};
			{OP_DMA_STOP, 3'h1}:   s = '{K_WR, R_EXT, 1'b0, ECR_ECP_DMAS, VAL_ZERO};
			{OP_DMA_STOP, 3'h2}:   s = '{K_WR, R_EXT, 1'b0, ECR_ECP, VAL_ZERO};
			{OP_DMA_RESUME, 3'h0}: s = '{K_DMA, R_EXT, 1'b0, 8'h03, VAL_ZERO};
			default:               s = '{K_END, R_EXT, 1'b0, VAL_ZERO, VAL_ZERO};
		endcase
		return s;
	endfunction : step_of

	function automatic logic [15:0] addr_of(input sel_t sel);
		case (sel)
			R_DFIFO:   addr_of = ADDR_DFIFO;
			R_AFIFO:   addr_of = PRIMARY_BASE + OFS_DATA;
			R_STATUS:  addr_of = PRIMARY_BASE + OFS_STATUS;
			R_CONTROL: addr_of = ADDR_DCR;
			default:   addr_of = ADDR_ECR;
		endcase
	endfunction : addr_of

	assign step_w      = step_of(cmd_r.op, idx_r);
	assign hold_done_w = (state_r == S_HOLD) && (cnt_r == 3'h0);
	assign push_w      = hold_done_w && (step_w.kind == K_RD);

	// ------------------------------------------------------------
	// Data pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sd_meta_r <= 8'h00;
			sd_sync_r <= 8'h00;
		end
		else
		begin
			sd_meta_r <= sd_in;
			sd_sync_r <= sd_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Sequencer and bus cycle engine
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state_r         <= S_IDLE;
			cmd_r           <= '{OP_ENTER, 8'h00};
			idx_r           <= 3'h0;
			cnt_r           <= 3'h0;
			cmd_ready_out   <= 1'b1;
			io_addr_out     <= 16'h0000;
			io_rd_n_out     <= 1'b1;
			io_wr_n_out     <= 1'b1;
			sd_out          <= 8'h00;
			sd_oe_out       <= 1'b0;
			rdata_r         <= 8'h00;
			dma_ctrl_en_out <= 1'b0;
			dma_unmask_out  <= 1'b0;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (cmd_valid_in)
					begin
						cmd_r         <= cmd_in;
						idx_r         <= 3'h0;
						cmd_ready_out <= 1'b0;
						state_r       <= S_FETCH;
					end
				end
				S_FETCH:
				begin
					if (step_w.kind == K_END)
					begin
						cmd_ready_out <= 1'b1;
						state_r       <= S_IDLE;
					end
					else if (step_w.kind == K_DMA)
					begin
						dma_unmask_out  <= step_w.val[0];
						dma_ctrl_en_out <= step_w.val[1];
						idx_r           <= idx_r + 3'h1;
					end
					else if (step_w.kind != K_RD || buf_ready_w)
					begin
						// Launch an address phase; writes drive data throughout
						io_addr_out <= addr_of(step_w.sel);
						sd_out      <= step_w.use_data ? cmd_r.data : step_w.val;
						sd_oe_out   <= (step_w.kind == K_WR);
						cnt_r       <= 3'(SETUP_CYC - 1);
						state_r     <= S_SETUP;
					end
				end
				S_SETUP:
				begin
					if (cnt_r == 3'h0)
					begin
						io_wr_n_out <= (step_w.kind != K_WR);
						io_rd_n_out <= (step_w.kind == K_WR);
						cnt_r       <= 3'(STROBE_CYC - 1);
						state_r     <= S_STROBE;
					end
					else
						cnt_r <= cnt_r - 3'h1;
				end
				S_STROBE:
				begin
					if (cnt_r == 3'h0)
					begin
						io_wr_n_out <= 1'b1;
						io_rd_n_out <= 1'b1;
						rdata_r     <= sd_sync_r;
						cnt_r       <= 3'(HOLD_CYC - 1);
						state_r     <= S_HOLD;
					end
					else
						cnt_r <= cnt_r - 3'h1;
				end
				S_HOLD:
				begin
					if (cnt_r == 3'h0)
					begin
						sd_oe_out <= 1'b0;
						state_r   <= S_FETCH;
						// A poll repeats until the masked flags match
						if (step_w.kind != K_POLL || (rdata_r & step_w.mask) == step_w.val)
							idx_r <= idx_r + 3'h1;
					end
					else
						cnt_r <= cnt_r - 3'h1;
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	// Last extended control value seen, for the user
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			status_out <= 8'h00;
		else if (hold_done_w && io_addr_out == ADDR_ECR && step_w.kind == K_POLL)
			status_out <= rdata_r;
	end

	// ------------------------------------------------------------
	// Receive buffer
	// ------------------------------------------------------------
	ecp_rx_buffer #(
		.WIDTH          (8)
	) u_rx_buffer (
		.clk_in         (clk_in),
		.rst_in         (rst_in),
		.push_valid_in  (push_w),
		.push_ready_out (buf_ready_w),
		.push_data_in   (rdata_r),
		.pop_valid_out  (rx_valid_out),
		.pop_ready_in   (rx_ready_in),
		.pop_data_out   (rx_data_out)
	);

	// ------------------------------------------------------------
	// Checks on the register write order
	// ------------------------------------------------------------
	logic       wr_n_q_r;
	logic       ecr_wr_w;
	logic       dcr_wr_w;
	logic [7:0] ecr_sh_r;
	logic [7:0] dcr_sh_r;
	logic       empty_seen_r;
	logic       nbusy_seen_r;

	assign ecr_wr_w = wr_n_q_r && !io_wr_n_out && io_addr_out == ADDR_ECR;
	assign dcr_wr_w = wr_n_q_r && !io_wr_n_out && io_addr_out == ADDR_DCR;

	// Shadows of what was last written and read
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_n_q_r     <= 1'b1;
			ecr_sh_r     <= ECR_STD;
			dcr_sh_r     <= VAL_ZERO;
			empty_seen_r <= 1'b0;
			nbusy_seen_r <= 1'b0;
		end
		else
		begin
			wr_n_q_r <= io_wr_n_out;
			if (ecr_wr_w)
				ecr_sh_r <= sd_out;
			if (dcr_wr_w)
				dcr_sh_r <= sd_out;
			if (hold_done_w && step_w.kind == K_POLL && io_addr_out == ADDR_ECR)
				empty_seen_r <= rdata_r[ECR_EMPTY_BIT];
			if (hold_done_w && step_w.kind == K_POLL && io_addr_out != ADDR_ECR)
				nbusy_seen_r <= rdata_r[DSR_NBUSY_BIT];
		end
	end

	fwd_exit_clean_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[7:6] == 2'b00 && ecr_sh_r[7:5] == MODE_ECP && !dcr_sh_r[DCR_DIR_BIT]
		|-> empty_seen_r && dcr_sh_r[1:0] == 2'b00) else $error("forward exit not clean");
	rev_exit_drained_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[7:6] == 2'b00 && ecr_sh_r[7:5] == MODE_ECP && dcr_sh_r[DCR_DIR_BIT]
		|-> empty_seen_r) else $error("reverse exit with data left");
	ecp_from_prog_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[7:5] == MODE_ECP && ecr_sh_r[7:5] != MODE_ECP
		|-> ecr_sh_r[7:6] == 2'b00) else $error("ECP entered from wrong mode");
	ecp_entry_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[7:5] == MODE_ECP |-> dcr_sh_r[1:0] == 2'b00)
		else $error("handshake bits set at ECP entry");
	dir_change_a: assert property (@(posedge clk_in) disable iff (rst_in)
		dcr_wr_w && sd_out[DCR_DIR_BIT] != dcr_sh_r[DCR_DIR_BIT] |-> ecr_sh_r[7:5] == MODE_BIDIR)
		else $error("direction changed outside mode 001");
	dma_unmask_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(dma_unmask_out) |-> ecr_sh_r[ECR_DMA_BIT] && !ecr_sh_r[ECR_SVC_BIT]
		&& dma_ctrl_en_out) else $error("channel unmasked before DMA set up");
	dma_stop_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[ECR_SVC_BIT] && ecr_sh_r[ECR_DMA_BIT] && !ecr_sh_r[ECR_SVC_BIT]
		|-> !dma_ctrl_en_out) else $error("service set while controller running");
	dma_resume_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[ECR_DMA_BIT] && !ecr_sh_r[ECR_DMA_BIT]
		|-> dma_ctrl_en_out ##1 !ecr_wr_w [*3]) else $error("DMA enabled with controller off");
	fwd_done_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecr_wr_w && sd_out[7:5] == MODE_BIDIR && ecr_sh_r[7:5] == MODE_ECP
		|-> nbusy_seen_r) else $error("left ECP while peripheral busy");
	rx_guard_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(io_rd_n_out) && io_addr_out == ADDR_DFIFO |-> !empty_seen_r && buf_ready_w)
		else $error("FIFO read while empty");

endmodule : ecp_host_ctrl

// *** tb/ecp_port_model.sv ***
// Behavioural model of the parallel port device reached through its ISA registers
`timescale 1ns/100ps
module ecp_port_model
	import ecp_host_pkg::*;
#(
	parameter int DEPTH   = 4,
	parameter int FWD_THR = 1,
	parameter int REV_THR = 1
)(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic        io_rd_n_in,
	input  wire logic        io_wr_n_in,
	input  wire logic [7:0]  host_data_in,
	input  wire logic        stall_in,
	output logic      [7:0]  dev_data_out
);
	localparam logic [15:0] A_DF  = PRIMARY_BASE_DEF + SECONDARY_OFS;
	localparam logic [15:0] A_ECR = A_DF + 16'h0002;
	localparam logic [15:0] A_DCR = PRIMARY_BASE_DEF + OFS_CONTROL;
	localparam logic [15:0] A_DSR = PRIMARY_BASE_DEF + OFS_STATUS;
	logic [7:0]  ecr_r;
	logic [7:0]  dcr_r;
	logic [7:0]  last_r;
	logic [7:0]  rd_val;
	logic [7:0]  last_wdata;
	logic [15:0] last_addr;
	logic        wr_prev_r;
	logic        rd_prev_r;
	logic        dir;
	logic        ecp;
	int          tick;
	int          fill_r;
	logic [7:0]  head_r;
	logic [8:0]  fifo[$];
	logic [8:0]  sent[$];
	logic [7:0]  feed[$] = '{8'hC3, 8'h3C, 8'h96};

	// Mode field and direction, forced forward in mode 000
	assign ecp = (ecr_r[7:5] == MODE_ECP);
	assign dir = (ecr_r[7:5] == MODE_STD) ? 1'b0 : dcr_r[5];

	// Read values; full and empty flags are read-only
	always @*
	begin
		rd_val = ~last_r;
		if (io_addr_in == A_ECR)
			rd_val = {ecr_r[7:2], fill_r >= DEPTH, fill_r == 0};
		else if (io_addr_in == A_DSR)
			rd_val = {~stall_in, 7'h7F};
		else if (io_addr_in == A_DCR)
			rd_val = {2'b11, dcr_r[5:0]};
		else if (io_addr_in == A_DF && fill_r != 0)
			rd_val = head_r;
	end

	// Released bus shows the inverse of the last value driven
	assign dev_data_out = io_rd_n_in ? ~last_r : rd_val;

	// Register writes, FIFO traffic and peripheral side
	always @(posedge clk_in)
	begin
		wr_prev_r <= io_wr_n_in;
		rd_prev_r <= io_rd_n_in;
		tick <= tick + 1;
		if (!io_rd_n_in)
			last_r <= rd_val;
		if (rst_in)
		begin
			ecr_r <= 8'h14;
			dcr_r <= 8'h00;
			tick <= 0;
			fifo.delete();
		end
		else
		begin
			if (!wr_prev_r && io_wr_n_in)
			begin
				last_addr <= io_addr_in;
				last_wdata <= host_data_in;
				if (io_addr_in == A_ECR)
					ecr_r <= {host_data_in[7:2], 2'b00};
				else if (io_addr_in == A_DCR)
					dcr_r <= host_data_in;
				else if (io_addr_in == A_DF && fifo.size() < DEPTH)
					fifo.push_back({1'b0, host_data_in});
				else if (io_addr_in == PRIMARY_BASE_DEF && ecp && !dir && fifo.size() < DEPTH)
					fifo.push_back({1'b1, host_data_in});
			end
			if (!rd_prev_r && io_rd_n_in && io_addr_in == A_DF && fifo.size() != 0)
				void'(fifo.pop_front());
			// Forward drain paced by busy and every fourth tick, reverse fill from the peripheral
			if (((ecp && !dir) || ecr_r[7:5] == MODE_FIFO) && !stall_in && fifo.size() != 0
				&& tick % 4 == 0)
				sent.push_back(fifo.pop_front());
			else if (ecp && dir && feed.size() != 0 && fifo.size() < DEPTH && tick % 4 == 0)
				fifo.push_back({1'b0, feed.pop_front()});
			// Threshold service conditions; the hardware set wins over a write
			if (ecp && !ecr_r[3] && !ecr_r[2]
				&& ((!dir && DEPTH - fill_r >= FWD_THR) || (dir && fill_r >= REV_THR)))
				ecr_r[2] <= 1'b1;
		end
		// Registered fill level and head word for the read values
		fill_r <= fifo.size();
		head_r <= (fifo.size() != 0) ? fifo[0][7:0] : 8'h00;
	end
endmodule : ecp_port_model

// *** tb/tb.sv ***
// Self-checking bench for the ECP host controller against the device model
`timescale 1ns/100ps
module tb;
	import ecp_host_pkg::*;
	localparam logic [15:0] A_AF  = PRIMARY_BASE_DEF;
	localparam logic [15:0] A_DF  = PRIMARY_BASE_DEF + SECONDARY_OFS;
	localparam logic [15:0] A_ECR = A_DF + 16'h0002;
	localparam logic [15:0] A_DCR = PRIMARY_BASE_DEF + OFS_CONTROL;
	typedef struct packed {
		op_t         op;
		logic [7:0]  data;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [7:0]  ecr;
		logic [7:0]  dcr;
		logic        en;
	} row_t;
	logic clk_in, rst_in, cmd_valid_in, rx_ready_in, cmd_ready_out, rx_valid_out;
	logic io_rd_n_out, io_wr_n_out, sd_oe_out, dma_ctrl_en_out, dma_unmask_out;
	logic periph_stall, done;
	cmd_t        cmd_in;
	logic [7:0]  rx_data_out, status_out, sd_in, sd_out;
	logic [15:0] io_addr_out;
	int          bad_count, total_checks, k;
	logic [7:0]  exp_rx[3] = '{8'hC3, 8'h3C, 8'h96};
	row_t rows[7] = '{
		'{OP_ENTER, 8'h00, A_ECR, 8'h74, 8'h74, 8'h04, 1'b0},
		'{OP_WR_DATA, 8'h5A, A_DF, 8'h5A, 8'h74, 8'h04, 1'b0},
		'{OP_WR_ADDR, 8'hA5, A_AF, 8'hA5, 8'h74, 8'h04, 1'b0},
		'{OP_DMA_START, 8'h00, A_ECR, 8'h78, 8'h78, 8'h04, 1'b1},
		'{OP_DMA_STOP, 8'h00, A_ECR, 8'h74, 8'h74, 8'h04, 1'b0},
		'{OP_DMA_RESUME, 8'h00, A_ECR, 8'h78, 8'h78, 8'h04, 1'b1},
		'{OP_DMA_STOP, 8'h00, A_ECR, 8'h74, 8'h74, 8'h04, 1'b0}};

	ecp_host_ctrl i_dut (.clk_in, .rst_in, .cmd_valid_in, .cmd_in, .cmd_ready_out,
		.rx_valid_out, .rx_ready_in, .rx_data_out, .status_out, .io_addr_out, .io_rd_n_out,
		.io_wr_n_out, .sd_in, .sd_out, .sd_oe_out, .dma_ctrl_en_out, .dma_unmask_out);
	ecp_port_model i_dev (.clk_in, .rst_in, .io_addr_in(io_addr_out), .io_rd_n_in(io_rd_n_out),
		.io_wr_n_in(io_wr_n_out), .host_data_in(sd_out), .stall_in(periph_stall),
		.dev_data_out(sd_in));

	// Clock
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Offers one command, then waits a bounded time for idle
	task automatic do_cmd(input op_t op, input logic [7:0] d, input int lim, output logic ok);
		cmd_valid_in <= 1'b1;
		cmd_in <= '{op, d};
		@(posedge clk_in);
		for (int n = 0; n < lim && cmd_ready_out !== 1'b1; n++)
			@(posedge clk_in);
		cmd_valid_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		for (int n = 0; n < lim && cmd_ready_out !== 1'b1; n++)
			@(posedge clk_in);
		ok = (cmd_ready_out === 1'b1);
	endtask : do_cmd

	task automatic run_row(input row_t r);
		logic ok;
		do_cmd(r.op, r.data, 3000, ok);
		check(ok, 1'b1);
		check(i_dev.last_addr, r.addr);
		check(i_dev.last_wdata, r.wdata);
		check(i_dev.ecr_r, r.ecr);
		check(i_dev.dcr_r, r.dcr);
		check(dma_ctrl_en_out, r.en);
		check(sd_oe_out, 1'b0);
		$display("Test of op %h ended", r.op);
	endtask : run_row

	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// Watchdog
	initial
	begin
		#(20 * 60000);
		bad_count++;
		give_verdict();
	end

	// Main sequence
	initial
	begin
		cmd_valid_in = 1'b0;
		cmd_in = '0;
		rx_ready_in = 1'b1;
		periph_stall = 1'b0;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		check({cmd_ready_out, io_rd_n_out, io_wr_n_out, sd_oe_out, dma_ctrl_en_out,
			dma_unmask_out, rx_valid_out}, 7'h70);
		$display("Test of reset ended");
		foreach (rows[i])
			run_row(rows[i]);
		check(dma_unmask_out, 1'b1);
		// Peripheral stalls: fifth write waits on the full flag
		periph_stall <= 1'b1;
		for (int i = 0; i < 5; i++)
			do_cmd(OP_WR_DATA, 8'h10 + i[7:0], 300, done);
		check(done, 1'b0);
		periph_stall <= 1'b0;
		for (int n = 0; n < 3000 && cmd_ready_out !== 1'b1; n++)
			@(posedge clk_in);
		repeat (100) @(posedge clk_in);
		check(16'(i_dev.sent.size()), 16'h0007);
		check(i_dev.sent[0], 9'h05A);
		check(i_dev.sent[1], 9'h1A5);
		for (int i = 0; i < 5; i++)
			check(i_dev.sent[2 + i], {1'b0, 8'h10 + i[7:0]});
		$display("Test of full FIFO ended");
		// Reverse reads with the receiver stalled
		run_row('{OP_TO_REV, 8'h00, A_ECR, 8'h74, 8'h74, 8'h24, 1'b0});
		rx_ready_in <= 1'b0;
		for (int i = 0; i < 3; i++)
			do_cmd(OP_RD_DATA, 8'h00, 300, done);
		check(done, 1'b0);
		rx_ready_in <= 1'b1;
		k = 0;
		for (int n = 0; n < 1500 && k < 3; n++)
		begin
			@(posedge clk_in);
			if (rx_valid_out === 1'b1)
			begin
				check(rx_data_out, exp_rx[k]);
				k++;
			end
		end
		check(16'(k), 16'h0003);
		for (int n = 0; n < 3000 && cmd_ready_out !== 1'b1; n++)
			@(posedge clk_in);
		$display("Test of reverse reads ended");
		run_row('{OP_TO_FWD, 8'h00, A_ECR, 8'h74, 8'h74, 8'h04, 1'b0});
		run_row('{OP_EXIT, 8'h00, A_DCR, 8'h04, 8'h34, 8'h04, 1'b0});
		check(status_out, {ECR_ECP[7:2], 2'b01});
		give_verdict();
	end
endmodule : tb
